// ### igs_pkg.sv
package igs_pkg;

  // bundle layout, byte 0 holds the template
  localparam int BUNDLE_W    = 128;
  localparam int BUNDLE_BYTES = 16;
  localparam int TMPL_W      = 5;
  localparam int TMPL_LSB    = 0;
  localparam int SLOT_W      = 41;
  localparam int SLOT0_LSB   = 5;
  localparam int NUM_SLOTS   = 3;
  localparam int QP_LSB      = 0;
  localparam int QP_W        = 6;
  localparam int NUM_PREDS   = 64;
  localparam int IP_W        = 64;
  localparam int DATA_W      = 64;
  localparam int MEM_WORDS   = 16;
  localparam int EXC_W       = 8;

  localparam logic [1:0] LAST_SLOT = 2'h2;
  localparam logic [1:0] LX_SLOT   = 2'h1;
  localparam logic [EXC_W-1:0] EXC_RSVD_TMPL = 8'h01;
  localparam logic [IP_W-1:0]  BUNDLE_STEP   = 64'h10;

  // group end causes
  localparam logic [2:0] CAUSE_NONE   = 3'h0;
  localparam logic [2:0] CAUSE_STOP   = 3'h1;
  localparam logic [2:0] CAUSE_BRANCH = 3'h2;
  localparam logic [2:0] CAUSE_BREAK  = 3'h3;
  localparam logic [2:0] CAUSE_RSVD   = 3'h4;

  // phases of one instruction, gray along fetch-read-exec-update
  typedef enum logic [1:0] {
    PH_FETCH = 2'b00,
    PH_READ  = 2'b01,
    PH_EXEC  = 2'b11,
    PH_UPDT  = 2'b10
  } igs_phase_e;

  // stop after slot n sits in bit n
  function automatic logic [2:0] igs_stops(input logic [TMPL_W-1:0] t);
    logic [2:0] m;
    m = {t[0], 2'b00};
    if (t[4:1] == 4'h1) m[1] = 1'b1;
    if (t[4:1] == 4'h5) m[0] = 1'b1;
    return m;
  endfunction

  function automatic logic igs_tmpl_rsvd(input logic [TMPL_W-1:0] t);
    return (t[4:1] == 4'h3) || (t[4:1] == 4'ha) ||
           (t[4:1] == 4'hd) || (t[4:1] == 4'hf);
  endfunction

  function automatic logic igs_tmpl_lx(input logic [TMPL_W-1:0] t);
    return t[4:1] == 4'h2;
  endfunction

endpackage

// ### igs_bundle_unpack.sv
`timescale 1ns/1ps
module igs_bundle_unpack
  import igs_pkg::*;
(
  // byte i of the bundle in bits 8i+7..8i
  input  wire logic [igs_pkg::BUNDLE_W-1:0]            bytes_in,
  // decoded view
  output logic [igs_pkg::TMPL_W-1:0]                   tmpl,
  output logic [igs_pkg::NUM_SLOTS-1:0][igs_pkg::SLOT_W-1:0] slots,
  output logic [2:0]                                   stops,
  output logic                                         rsvd,
  output logic                                         lx
);
  import igs_pkg::*;

  logic [BUNDLE_W-1:0] value;

  // little-endian: lowest address byte is least significant
  genvar b;
  generate
    for (b = 0; b < BUNDLE_BYTES; b++) begin : g_byte
      assign value[8*b +: 8] = bytes_in[8*b +: 8];
    end
  endgenerate

  assign tmpl = value[TMPL_LSB +: TMPL_W];

  genvar s;
  generate
    for (s = 0; s < NUM_SLOTS; s++) begin : g_slot
      assign slots[s] = value[SLOT0_LSB + s*SLOT_W +: SLOT_W];
    end
  endgenerate

  // a long pair ends on slot 1, so its closing stop is copied there
  assign stops = igs_stops(tmpl) | {1'b0, lx && tmpl[0], 1'b0};
  assign rsvd  = igs_tmpl_rsvd(tmpl);
  assign lx    = igs_tmpl_lx(tmpl);

endmodule // igs_bundle_unpack

// ### igs_pred_file.sv
`timescale 1ns/1ps
module igs_pred_file
  import igs_pkg::*;
(
  // clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire logic                    clk_en,
  // read port, committed state only
  input  wire logic [igs_pkg::QP_W-1:0] rd_idx,
  output logic                         rd_val,
  // deferred write port
  input  wire logic                    wr_en,
  input  wire logic [igs_pkg::QP_W-1:0] wr_idx,
  input  wire logic                    wr_val,
  // make deferred writes architectural
  input  wire logic                    commit
);
  import igs_pkg::*;

  logic [NUM_PREDS-1:0] pr_r, pr_nxt;
  logic [NUM_PREDS-1:0] pend_we_r, pend_we_nxt;
  logic [NUM_PREDS-1:0] pend_v_r, pend_v_nxt;

  // reads never see writes of the open group
  assign rd_val = (rd_idx == '0) ? 1'b1 : pr_r[rd_idx];

  always_comb begin
    pr_nxt      = pr_r;
    pend_we_nxt = pend_we_r;
    pend_v_nxt  = pend_v_r;
    if (wr_en && (wr_idx != '0)) begin
      pend_we_nxt[wr_idx] = 1'b1;
      pend_v_nxt[wr_idx]  = wr_val;
    end
    if (commit) begin
      pr_nxt      = (pr_r & ~pend_we_nxt) | (pend_v_nxt & pend_we_nxt);
      pr_nxt[0]   = 1'b1;
      pend_we_nxt = '0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pr_r      <= {{(NUM_PREDS-1){1'b0}}, 1'b1};
      pend_we_r <= '0;
      pend_v_r  <= '0;
    end else if (clk_en) begin
      pr_r      <= pr_nxt;
      pend_we_r <= pend_we_nxt;
      pend_v_r  <= pend_v_nxt;
    end
  end

endmodule // igs_pred_file

// ### igs_sequencer.sv
`timescale 1ns/1ps
module igs_sequencer
  import igs_pkg::*;
#(
  parameter int MEM_WORDS = igs_pkg::MEM_WORDS
) (
  // clock, reset, enable
  input  wire logic                       ref_clk,
  input  wire logic                       rst_n,
  input  wire logic                       clk_en,
  // bundle stream
  input  wire logic                       bnd_valid,
  input  wire logic [igs_pkg::BUNDLE_W-1:0] bnd_bytes,
  input  wire logic [igs_pkg::IP_W-1:0]   bnd_addr,
  output logic                            bnd_ready_r,
  // issue to the executor
  output logic                            iss_valid_r,
  output logic [igs_pkg::SLOT_W-1:0]      iss_word_r,
  output logic [igs_pkg::IP_W-1:0]        iss_ip_r,
  output logic [1:0]                      iss_slot_r,
  output logic                            iss_qp_true_r,
  // executor answer
  input  wire logic                       ex_done,
  input  wire logic                       ex_fault,
  input  wire logic [igs_pkg::EXC_W-1:0]  ex_code,
  input  wire logic                       ex_taken,
  input  wire logic                       ex_break_b,
  input  wire logic                       ex_rsvd_b,
  input  wire logic                       ex_redirect,
  input  wire logic [igs_pkg::IP_W-1:0]   ex_target,
  input  wire logic                       ex_sync,
  input  wire logic                       ex_pr_we,
  input  wire logic [igs_pkg::QP_W-1:0]   ex_pr_dst,
  input  wire logic                       ex_pr_val,
  input  wire logic                       ex_ld,
  input  wire logic                       ex_st,
  input  wire logic                       ex_adv,
  input  wire logic                       ex_chk,
  input  wire logic [$clog2(MEM_WORDS)-1:0] ex_maddr,
  input  wire logic [igs_pkg::DATA_W-1:0] ex_sdata,
  // results
  output logic                            res_valid_r,
  output logic [igs_pkg::DATA_W-1:0]      ld_data_r,
  output logic                            advanced_load_table_hit_r,
  // group and flow events
  output logic                            grp_end_r,
  output logic [2:0]                      grp_cause_r,
  output logic                            redir_valid_r,
  output logic [igs_pkg::IP_W-1:0]        redir_ip_r,
  output logic                            exc_valid_r,
  output logic [igs_pkg::IP_W-1:0]        exc_ip_r,
  output logic [1:0]                      exc_slot_r,
  output logic [igs_pkg::EXC_W-1:0]       exc_code_r
);
  import igs_pkg::*;

  localparam int AW = $clog2(MEM_WORDS);

  ////////////////////////////////////////////////////////////////////////////
  // bundle decode and predicate state

  logic [TMPL_W-1:0]                 u_tmpl;
  logic [NUM_SLOTS-1:0][SLOT_W-1:0]  u_slots;
  logic [2:0]                        u_stops;
  logic                              u_rsvd;
  logic                              u_lx;

  igs_bundle_unpack u_unpack (
    .bytes_in (bnd_bytes),
    .tmpl     (u_tmpl),
    .slots    (u_slots),
    .stops    (u_stops),
    .rsvd     (u_rsvd),
    .lx       (u_lx)
  );

  igs_phase_e                        phase_r, phase_nxt;
  logic [NUM_SLOTS-1:0][SLOT_W-1:0]  slots_r, slots_nxt;
  logic [2:0]                        stops_r, stops_nxt;
  logic                              rsvd_r, rsvd_nxt;
  logic                              lx_r, lx_nxt;
  logic [IP_W-1:0]                   ip_r, ip_nxt;
  logic [1:0]                        slot_r, slot_nxt;
  logic                              hold_r, hold_nxt;
  logic                              qp_r, qp_nxt;

  logic                              pr_rd;
  logic                              pr_we;
  logic                              commit;
  logic                  x_f_r, x_t_r, x_bb_r, x_rb_r, x_red_r, x_s_r;
  logic                  x_pw_r, x_pv_r, x_ld_r, x_st_r, x_adv_r, x_chk_r;
  logic [EXC_W-1:0]      x_c_r;
  logic [IP_W-1:0]       x_tg_r;
  logic [QP_W-1:0]       x_pd_r;
  logic [AW-1:0]         x_a_r;
  logic [DATA_W-1:0]     x_d_r;

  igs_pred_file u_preds (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .rd_idx  (slots_r[slot_r][QP_LSB +: QP_W]),
    .rd_val  (pr_rd),
    .wr_en   (pr_we),
    .wr_idx  (x_pd_r),
    .wr_val  (x_pv_r),
    .commit  (commit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // captured execute results, held for the update phase

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {x_f_r, x_t_r, x_bb_r, x_rb_r, x_red_r, x_s_r} <= '0;
      {x_pw_r, x_pv_r, x_ld_r, x_st_r, x_adv_r, x_chk_r} <= '0;
      x_c_r  <= '0;
      x_tg_r <= '0;
      x_pd_r <= '0;
      x_a_r  <= '0;
      x_d_r  <= '0;
    end else if (clk_en && (phase_r == PH_EXEC) && ex_done) begin
      {x_f_r, x_t_r, x_bb_r, x_rb_r, x_red_r, x_s_r} <=
        {ex_fault, ex_taken, ex_break_b, ex_rsvd_b, ex_redirect, ex_sync};
      {x_pw_r, x_pv_r, x_ld_r, x_st_r, x_adv_r, x_chk_r} <=
        {ex_pr_we, ex_pr_val, ex_ld, ex_st, ex_adv, ex_chk};
      x_c_r  <= ex_code;
      x_tg_r <= ex_target;
      x_pd_r <= ex_pr_dst;
      x_a_r  <= ex_maddr;
      x_d_r  <= ex_sdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory and advanced load table, updated in program order

  logic [DATA_W-1:0]     mem_r [MEM_WORDS];
  logic [MEM_WORDS-1:0]  advanced_load_table_r, advanced_load_table_nxt;
  logic                  mem_we;

  // a predicated-off instruction reaches no memory or table state
  logic upd, act, fault, ends;
  assign upd   = (phase_r == PH_UPDT);
  assign act   = upd && qp_r;
  assign fault = act && (x_f_r || x_bb_r || x_rb_r);
  assign ends  = stops_r[slot_r] ||
                 (act && (x_t_r || x_bb_r || x_rb_r));
  assign mem_we = act && !fault && x_st_r;
  assign pr_we  = act && !fault && x_pw_r;

  always_comb begin
    advanced_load_table_nxt = advanced_load_table_r;
    if (act && !fault) begin
      if (x_st_r) advanced_load_table_nxt[x_a_r] = 1'b0;
      if (x_adv_r) advanced_load_table_nxt[x_a_r] = 1'b1;
    end
  end

  // stores land in the update phase, so any later read sees them
  always_ff @(posedge ref_clk) begin
    if (clk_en && mem_we) mem_r[x_a_r] <= x_d_r;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) advanced_load_table_r <= '0;
    else if (clk_en) advanced_load_table_r <= advanced_load_table_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing

  logic last;
  assign last = (slot_r == LAST_SLOT) || (lx_r && (slot_r == LX_SLOT));

  logic                  bnd_ready_nxt, iss_valid_nxt, iss_qp_nxt;
  logic [SLOT_W-1:0]     iss_word_nxt;
  logic [IP_W-1:0]       iss_ip_nxt, redir_ip_nxt, exc_ip_nxt;
  logic [1:0]            iss_slot_nxt, exc_slot_nxt;
  logic                  res_valid_nxt, advanced_load_table_hit_nxt, grp_end_nxt;
  logic [DATA_W-1:0]     ld_data_nxt;
  logic [2:0]            grp_cause_nxt;
  logic                  redir_valid_nxt, exc_valid_nxt;
  logic [EXC_W-1:0]      exc_code_nxt;

  always_comb begin
    phase_nxt       = phase_r;
    slots_nxt       = slots_r;
    stops_nxt       = stops_r;
    rsvd_nxt        = rsvd_r;
    lx_nxt          = lx_r;
    ip_nxt          = ip_r;
    slot_nxt        = slot_r;
    hold_nxt        = hold_r;
    qp_nxt          = qp_r;
    commit          = 1'b0;
    bnd_ready_nxt   = 1'b0;
    iss_valid_nxt   = 1'b0;
    iss_word_nxt    = iss_word_r;
    iss_ip_nxt      = iss_ip_r;
    iss_slot_nxt    = iss_slot_r;
    iss_qp_nxt      = iss_qp_true_r;
    res_valid_nxt   = 1'b0;
    ld_data_nxt     = ld_data_r;
    advanced_load_table_hit_nxt    = advanced_load_table_hit_r;
    grp_end_nxt     = 1'b0;
    grp_cause_nxt   = grp_cause_r;
    redir_valid_nxt = 1'b0;
    redir_ip_nxt    = redir_ip_r;
    exc_valid_nxt   = 1'b0;
    exc_ip_nxt      = exc_ip_r;
    exc_slot_nxt    = exc_slot_r;
    exc_code_nxt    = exc_code_r;
    unique case (phase_r)
      PH_FETCH: begin
        bnd_ready_nxt = 1'b1;
        if (bnd_valid && bnd_ready_r) begin
          // bundles are taken strictly in stream order
          slots_nxt     = u_slots;
          stops_nxt     = u_stops;
          rsvd_nxt      = u_rsvd;
          lx_nxt        = u_lx;
          ip_nxt        = bnd_addr;
          slot_nxt      = 2'h0;
          bnd_ready_nxt = 1'b0;
          phase_nxt     = PH_READ;
        end
      end
      PH_READ: begin
        if (rsvd_r) begin
          // no slot of an undefined template executes
          commit        = 1'b1;
          exc_valid_nxt = 1'b1;
          exc_ip_nxt    = ip_r;
          exc_slot_nxt  = 2'h0;
          exc_code_nxt  = EXC_RSVD_TMPL;
          bnd_ready_nxt = 1'b1;
          phase_nxt     = PH_FETCH;
        end else begin
          qp_nxt        = pr_rd;
          iss_valid_nxt = 1'b1;
          iss_word_nxt  = slots_r[slot_r];
          iss_ip_nxt    = ip_r;
          iss_slot_nxt  = slot_r;
          iss_qp_nxt    = pr_rd;
          phase_nxt     = PH_EXEC;
        end
      end
      PH_EXEC: begin
        if (ex_done) phase_nxt = PH_UPDT;
      end
      PH_UPDT: begin
        res_valid_nxt = 1'b1;
        if (act && !fault) begin
          // load data is taken before this or any later store
          if (x_ld_r) ld_data_nxt = mem_r[x_a_r];
          if (x_chk_r) advanced_load_table_hit_nxt = advanced_load_table_r[x_a_r];
          if (x_s_r) hold_nxt = 1'b1;
        end
        if (ends) begin
          grp_end_nxt   = 1'b1;
          grp_cause_nxt = !act                ? CAUSE_STOP   :
                          x_bb_r              ? CAUSE_BREAK  :
                          x_rb_r              ? CAUSE_RSVD   :
                          x_t_r               ? CAUSE_BRANCH : CAUSE_STOP;
        end
        if (fault) begin
          // later slots are dropped, so only the first fault shows
          commit        = 1'b1;
          exc_valid_nxt = 1'b1;
          exc_ip_nxt    = ip_r;
          exc_slot_nxt  = slot_r;
          exc_code_nxt  = x_c_r;
          hold_nxt      = 1'b0;
          bnd_ready_nxt = 1'b1;
          phase_nxt     = PH_FETCH;
        end else if (act && (x_t_r || x_red_r)) begin
          // a redirect that is no branch keeps the group open
          commit          = ends || hold_r || x_s_r;
          hold_nxt        = hold_nxt && !commit;
          redir_valid_nxt = 1'b1;
          redir_ip_nxt    = x_tg_r;
          bnd_ready_nxt   = 1'b1;
          phase_nxt       = PH_FETCH;
        end else begin
          // sync drains pending writes before the next fetch
          commit = ends || (last && hold_nxt);
          if (commit) hold_nxt = 1'b0;
          if (last) begin
            bnd_ready_nxt = 1'b1;
            phase_nxt     = PH_FETCH;
          end else begin
            slot_nxt  = slot_r + 2'h1;
            phase_nxt = PH_READ;
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r       <= PH_FETCH;
      slots_r       <= '0;
      stops_r       <= '0;
      rsvd_r        <= 1'b0;
      lx_r          <= 1'b0;
      ip_r          <= '0;
      slot_r        <= '0;
      hold_r        <= 1'b0;
      qp_r          <= 1'b0;
      bnd_ready_r   <= 1'b1;
      iss_valid_r   <= 1'b0;
      iss_word_r    <= '0;
      iss_ip_r      <= '0;
      iss_slot_r    <= '0;
      iss_qp_true_r <= 1'b0;
      res_valid_r   <= 1'b0;
      ld_data_r     <= '0;
      advanced_load_table_hit_r    <= 1'b0;
      grp_end_r     <= 1'b0;
      grp_cause_r   <= CAUSE_NONE;
      redir_valid_r <= 1'b0;
      redir_ip_r    <= '0;
      exc_valid_r   <= 1'b0;
      exc_ip_r      <= '0;
      exc_slot_r    <= '0;
      exc_code_r    <= '0;
    end else if (clk_en) begin
      phase_r       <= phase_nxt;
      slots_r       <= slots_nxt;
      stops_r       <= stops_nxt;
      rsvd_r        <= rsvd_nxt;
      lx_r          <= lx_nxt;
      ip_r          <= ip_nxt;
      slot_r        <= slot_nxt;
      hold_r        <= hold_nxt;
      qp_r          <= qp_nxt;
      bnd_ready_r   <= bnd_ready_nxt;
      iss_valid_r   <= iss_valid_nxt;
      iss_word_r    <= iss_word_nxt;
      iss_ip_r      <= iss_ip_nxt;
      iss_slot_r    <= iss_slot_nxt;
      iss_qp_true_r <= iss_qp_nxt;
      res_valid_r   <= res_valid_nxt;
      ld_data_r     <= ld_data_nxt;
      advanced_load_table_hit_r    <= advanced_load_table_hit_nxt;
      grp_end_r     <= grp_end_nxt;
      grp_cause_r   <= grp_cause_nxt;
      redir_valid_r <= redir_valid_nxt;
      redir_ip_r    <= redir_ip_nxt;
      exc_valid_r   <= exc_valid_nxt;
      exc_ip_r      <= exc_ip_nxt;
      exc_slot_r    <= exc_slot_nxt;
      exc_code_r    <= exc_code_nxt;
    end
  end

endmodule // igs_sequencer

// ### igs_seq_assertions.sv
`timescale 1ns/1ps
module igs_seq_chk
  import igs_pkg::*;
(
  // clock and reset
  input wire logic                        ref_clk,
  input wire logic                        rst_n,
  input wire logic                        clk_en,
  // bundle stream
  input wire logic                        bnd_valid,
  input wire logic [igs_pkg::BUNDLE_W-1:0] bnd_bytes,
  input wire logic                        bnd_ready_r,
  // issue and answer
  input wire logic                        iss_valid_r,
  input wire logic [igs_pkg::SLOT_W-1:0]  iss_word_r,
  input wire logic                        iss_qp_true_r,
  input wire logic                        ex_done,
  input wire logic                        ex_fault,
  input wire logic                        ex_taken,
  input wire logic                        ex_break_b,
  input wire logic                        ex_rsvd_b,
  input wire logic                        ex_redirect,
  // events
  input wire logic                        res_valid_r,
  input wire logic                        grp_end_r,
  input wire logic [2:0]                  grp_cause_r,
  input wire logic                        redir_valid_r,
  input wire logic                        exc_valid_r,
  input wire logic [igs_pkg::EXC_W-1:0]   exc_code_r
);
  import igs_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic take;
  logic fin;
  logic plain;
  assign take = bnd_valid && bnd_ready_r && clk_en;
  assign fin = iss_valid_r && ex_done && clk_en;
  assign plain = !(ex_fault || ex_taken || ex_break_b || ex_rsvd_b);
  ////////////////////////////////////////////////////////////////////////////
  issue_lat_a: assert property (
    take && !igs_tmpl_rsvd(bnd_bytes[4:0]) |-> ##2 iss_valid_r)
    else $error("issue not two cycles after bundle taken");
  ready_drop_a: assert property (take |=> !bnd_ready_r)
    else $error("bundle stream still ready after take");
  rsvd_exc_a: assert property (
    take && igs_tmpl_rsvd(bnd_bytes[4:0])
    |-> ##[1:6] exc_valid_r && exc_code_r == EXC_RSVD_TMPL)
    else $error("reserved template without its exception");
  update_lat_a: assert property (
    fin && plain && !ex_redirect |-> ##2 res_valid_r)
    else $error("update not two cycles after done");
  true_pred_a: assert property (
    iss_valid_r && iss_word_r[5:0] == 6'h00 |-> iss_qp_true_r)
    else $error("hardwired predicate read as false");
  taken_end_a: assert property (
    fin && iss_qp_true_r && ex_taken && !ex_fault
    |-> ##2 grp_end_r && grp_cause_r == CAUSE_BRANCH)
    else $error("taken branch did not end the group");
  redir_open_a: assert property (
    fin && iss_qp_true_r && ex_redirect && plain
    |-> ##2 redir_valid_r && !(grp_end_r && grp_cause_r != CAUSE_STOP))
    else $error("redirect closed the group");
  exc_once_a: assert property (
    exc_valid_r |-> bnd_ready_r && !iss_valid_r ##1 !exc_valid_r)
    else $error("exception not alone or bundle not released");
endmodule // igs_seq_chk

bind igs_sequencer igs_seq_chk u_chk (
  .ref_clk, .rst_n, .clk_en, .bnd_valid, .bnd_bytes, .bnd_ready_r,
  .iss_valid_r, .iss_word_r, .iss_qp_true_r, .ex_done, .ex_fault,
  .ex_taken, .ex_break_b, .ex_rsvd_b, .ex_redirect, .res_valid_r,
  .grp_end_r, .grp_cause_r, .redir_valid_r, .exc_valid_r, .exc_code_r
);

// ### igs_exec_model.sv
`timescale 1ns/1ps
module igs_exec_model
  import igs_pkg::*;
(
  // clock, reset, answer delay
  input  wire logic                       ref_clk,
  input  wire logic                       rst_n,
  input  wire logic [1:0]                 dly,
  // issued slot
  input  wire logic                       iss_valid_r,
  input  wire logic [igs_pkg::SLOT_W-1:0] iss_word_r,
  // answer
  output logic                            ex_done,
  output logic [igs_pkg::SLOT_W-1:0]      w
);
  import igs_pkg::*;
  logic [1:0]        cnt_r;
  logic [1:0]        cnt_nxt;
  logic [SLOT_W-1:0] word_r;
  logic [SLOT_W-1:0] word_nxt;
  always_comb begin
    cnt_nxt = cnt_r;
    word_nxt = word_r;
    if (iss_valid_r) begin
      cnt_nxt = dly;
      word_nxt = iss_word_r;
    end else if (cnt_r != 2'h0) begin
      cnt_nxt = cnt_r - 2'h1;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 2'h0;
      word_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      word_r <= word_nxt;
    end
  end
  // one answer per issued slot, prompt or late
  assign ex_done = iss_valid_r ? (dly == 2'h0) : (cnt_r == 2'h1);
  // idle answer lines flip so a stale answer never looks valid
  assign w = ex_done ? (iss_valid_r ? iss_word_r : word_r) : ~word_r;
endmodule // igs_exec_model

// ### test_igs_sequencer.sv
`timescale 1ns/1ps
module test_igs_sequencer;
  import igs_pkg::*;
  localparam logic [40:0] LD = 41'h40, ST = 41'h80, TK = 41'h100;
  localparam logic [40:0] FT = 41'h200, PW = 41'h400, PV = 41'h20000;
  localparam logic [40:0] BB = 41'h1 << 38, RB = 41'h1 << 39;
  localparam logic [40:0] RD = 41'h1 << 40, AV = 41'h1 << 27, CK = AV << 1;
  logic ref_clk, rst_n, clk_en, bnd_valid, bnd_ready_r, iss_valid_r;
  logic iss_qp_true_r, ex_done, res_valid_r, advanced_load_table_hit_r, grp_end_r;
  logic redir_valid_r, exc_valid_r;
  logic [BUNDLE_W-1:0] bnd_bytes;
  logic [IP_W-1:0]     bnd_addr, iss_ip_r, redir_ip_r, exc_ip_r, ip;
  logic [SLOT_W-1:0]   iss_word_r, w, last_w;
  logic [1:0]          iss_slot_r, exc_slot_r, dly;
  logic [EXC_W-1:0]    exc_code_r;
  logic [DATA_W-1:0]   ld_data_r;
  logic [2:0]          grp_cause_r;
  logic [2:0]          iq[$];
  logic [2:0]          gq[$];
  logic [9:0]          xq[$];
  logic [63:0]         lq[$];
  int                  mismatches, n_tests;

  igs_sequencer #(.MEM_WORDS(16)) uut (
    .ref_clk, .rst_n, .clk_en, .bnd_valid, .bnd_bytes, .bnd_addr,
    .bnd_ready_r, .iss_valid_r, .iss_word_r, .iss_ip_r, .iss_slot_r,
    .iss_qp_true_r, .ex_done, .ex_fault(w[9]), .ex_code(w[29:22]),
    .ex_taken(w[8]), .ex_break_b(w[38]), .ex_rsvd_b(w[39]),
    .ex_redirect(w[40]), .ex_target({23'h0, w}), .ex_sync(1'b0),
    .ex_pr_we(w[10]), .ex_pr_dst(w[16:11]), .ex_pr_val(w[17]),
    .ex_ld(w[6]), .ex_st(w[7]), .ex_adv(w[27]), .ex_chk(w[28]),
    .ex_maddr(w[21:18]), .ex_sdata({56'h0, w[37:30]}), .res_valid_r,
    .ld_data_r, .advanced_load_table_hit_r, .grp_end_r, .grp_cause_r, .redir_valid_r,
    .redir_ip_r, .exc_valid_r, .exc_ip_r, .exc_slot_r, .exc_code_r);
  igs_exec_model u_exec (.ref_clk, .rst_n, .dly, .iss_valid_r,
    .iss_word_r, .ex_done, .w);
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, g);
    end
  endtask
  function automatic logic [40:0] op(input int q, a, s,
                                     input logic [40:0] f);
    return f | 41'(q) | (41'(a) << 18) | (41'(s) << 30);
  endfunction
  task automatic wait_ready();
    for (int n = 0; bnd_ready_r !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
      if (n > 300) begin
        mismatches++;
        give_verdict();
      end
    end
  endtask
  // offer one bundle, then wait until it is finished and results land
  task automatic send(input logic [4:0] t, input logic [40:0] a, b, c);
    wait_ready();
    @(posedge ref_clk);
    #1;
    bnd_bytes = {c, b, a, t};
    bnd_addr = ip;
    bnd_valid = 1'b1;
    @(posedge ref_clk);
    #1;
    bnd_valid = 1'b0;
    bnd_bytes = ~bnd_bytes;
    bnd_addr = ~bnd_addr;
    repeat (2) @(posedge ref_clk);
    #1;
    wait_ready();
    ip = ip + BUNDLE_STEP;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  task automatic flush();
    iq.delete();
    gq.delete();
    xq.delete();
    lq.delete();
  endtask
  always @(negedge ref_clk) begin
    if (iss_valid_r === 1'b1) begin
      iq.push_back({iss_slot_r, iss_qp_true_r});
      last_w = iss_word_r;
      chk("issue address", ip, iss_ip_r);
    end
    if (res_valid_r === 1'b1 && last_w[6] === 1'b1) lq.push_back(ld_data_r);
    if (grp_end_r === 1'b1) gq.push_back(grp_cause_r);
    if (exc_valid_r === 1'b1) xq.push_back({exc_slot_r, exc_code_r});
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic scn_stops();
    logic [4:0] tm[6] = '{5'h00, 5'h01, 5'h02, 5'h0a, 5'h0b, 5'h05};
    int ends[6] = '{0, 1, 1, 1, 2, 1};
    foreach (tm[i]) begin
      flush();
      send(tm[i], 41'h0, 41'h0, 41'h0);
      chk("stop count", ends[i], gq.size());
      for (int s = 0; s < (i == 5 ? 2 : 3); s++)
        chk("slot order", s, iq[s][2:1]);
    end
  endtask
  // no register read follows a write to it within a group
  // nor any such pair on an ignored register
  task automatic scn_preds();
    flush();
    send(5'h01, op(5, 0, 0, 0), op(0, 0, 0, PW | 41'h5 << 11 | PV),
         op(0, 0, 0, PW));
    send(5'h01, op(5, 0, 0, 0), op(0, 0, 0, 0), 41'h0);
    chk("read before group write", 0, iq[0][0]);
    chk("next group view", 1, iq[3][0]);
    chk("hardwired predicate", 1, iq[4][0]);
  endtask
  task automatic scn_memory();
    flush();
    dly = 2'h2;
    send(5'h00, op(0, 2, 8'h11, ST), op(0, 2, 0, LD), op(0, 2, 8'h22, ST));
    send(5'h01, op(0, 2, 8'h33, ST), op(7, 2, 8'h44, ST), op(0, 2, 0, LD));
    send(5'h01, op(0, 2, 0, LD), op(0, 5, 0, AV), op(0, 5, 0, CK));
    dly = 2'h0;
    chk("load after store", 64'h11, lq[0]);
    chk("cancelled store", 64'h33, lq[1]);
    chk("last store wins", 64'h33, lq[2]);
    chk("table hit", 1, advanced_load_table_hit_r);
  endtask
  task automatic scn_faults();
    flush();
    send(5'h00, op(0, 0, 0, PW | 41'h6 << 11 | PV),
         op(0, 0, 0, FT | 41'h33 << 22), op(0, 0, 0, FT | 41'h44 << 22));
    chk("fault count", 1, xq.size());
    chk("fault report", {2'h1, 8'h33}, xq[0]);
    chk("slots after fault", 2, iq.size());
    chk("fault address", ip - BUNDLE_STEP, exc_ip_r);
    chk("issued word", FT | 41'h33 << 22, last_w);
    send(5'h01, op(6, 0, 0, 0), 41'h0, 41'h0);
    chk("earlier write kept", 1, iq[2][0]);
    flush();
    send(5'h06, 41'h0, 41'h0, 41'h0);
    chk("template fault", EXC_RSVD_TMPL, xq[0][7:0]);
    chk("reserved issues", 0, iq.size());
  endtask
  task automatic scn_ends();
    logic [40:0] fl[4] = '{TK, BB, RB, RD};
    logic [2:0] cz[4] = '{CAUSE_BRANCH, CAUSE_BREAK, CAUSE_RSVD, CAUSE_NONE};
    foreach (fl[i]) begin
      flush();
      send(5'h00, fl[i], 41'h0, 41'h0);
      chk("end cause", cz[i], gq.size() ? gq[0] : 3'h0);
    end
    chk("redirect target", RD, redir_ip_r);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    bnd_valid = 1'b0;
    bnd_bytes = '0;
    bnd_addr = '0;
    dly = 2'h0;
    ip = 64'h1000;
    last_w = '0;
    mismatches = 0;
    n_tests = 0;
    repeat (8) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    scn_stops();
    scn_preds();
    scn_memory();
    scn_faults();
    scn_ends();
    give_verdict();
  end
endmodule // test_igs_sequencer
